// ### inc/timer16_defs.svh
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH
// Register byte offsets
`define T16_OFS_CNT_HIGH 8'h00
`define T16_OFS_CNT_LOW 8'h04
`define T16_OFS_SHD_HIGH 8'h08
`define T16_OFS_SHD_LOW 8'h0C
`define T16_OFS_STATUS 8'h10
`define T16_OFS_CTRL_ONE 8'h14
`define T16_OFS_CTRL_TWO 8'h18
// Field positions
`define T16_BIT_OVF_FLAG 0
`define T16_BIT_OVF_IRQ_EN 0
`define T16_BIT_CLK_SEL_LO 0
`define T16_BIT_CLK_SEL_HI 1
`define T16_BIT_EXT_EDGE 2
// Reset and reload values
`define T16_CNT_RESET 16'hFFFC
`define T16_CNT_MAX 16'hFFFF
`define T16_CTRL_RESET 8'h00
// Prescaler masks: divide by 2, 4, 8
`define T16_PRESC_DIV2 3'h1
`define T16_PRESC_DIV4 3'h3
`define T16_PRESC_DIV8 3'h7
`define T16_CLK_SEL_EXT 2'h3
// Bus answers
`define T16_RESP_OKAY 2'h0
`define T16_RESP_SLVERR 2'h2
`endif

// ### inc/timer16_pkg.sv
package timer16_pkg;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;
    typedef enum logic [2:0] {
        REG_CNT_HIGH = 3'b000,
        REG_CNT_LOW = 3'b001,
        REG_SHD_HIGH = 3'b010,
        REG_SHD_LOW = 3'b011,
        REG_STATUS = 3'b100,
        REG_CTRL_ONE = 3'b101,
        REG_CTRL_TWO = 3'b110,
        REG_NONE = 3'b111
    } reg_sel_t;
endpackage

// ### rtl/timer16_counter_overflow.sv
// Behaviour
// - Internal tick is CPU clock over 2/4/8
// - 16-bit up-counter as high and low bytes
// - Low byte writes force counter to FFFCh
// - Reset value FFFCh, the only reload
// - Two read-only views, same count
// - High read first buffers the low byte
// - Buffer holds until low byte read
// - Lone low read returns live low byte
// - Rollover FFFFh to 0000h sets overflow flag
// - Interrupt only if enabled and unmasked
// - Clear: status read, then low access
// - Shadow low access never clears flag
// - Counter unaffected by wait mode
// - Halt stops counter, resumes held count
// - Unbonded input seen as logic one
// - Instances independent, in step after reset
// - Both select bits one picks external clock
// - Edge select picks active external edge
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defs.svh"

module timer16_counter_overflow #(
    parameter bit EXT_PIN_BONDED = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire timer16_pkg::axi_req_t axiReq,
    output timer16_pkg::axi_rsp_t axiRsp,
    input wire logic extTimerClockPin,
    input wire logic cpuIrqMask,
    input wire logic haltMode,
    output logic timerIrq
);
    import timer16_pkg::*;

    typedef struct packed {
        axi_rsp_t rsp;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [15:0] count;
        logic [2:0] presc;
        logic [2:0] extSync;
        logic extLvl;
        logic seqOpen;
        logic [7:0] lowBuf;
        logic ovfFlag;
        logic clrArmed;
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // =========================================================
    // Address decode
    function automatic reg_sel_t decodeReg(input logic [7:0] addr);
        reg_sel_t sel;
        sel = REG_NONE;
        unique case (addr)
            `T16_OFS_CNT_HIGH: sel = REG_CNT_HIGH;
            `T16_OFS_CNT_LOW: sel = REG_CNT_LOW;
            `T16_OFS_SHD_HIGH: sel = REG_SHD_HIGH;
            `T16_OFS_SHD_LOW: sel = REG_SHD_LOW;
            `T16_OFS_STATUS: sel = REG_STATUS;
            `T16_OFS_CTRL_ONE: sel = REG_CTRL_ONE;
            `T16_OFS_CTRL_TWO: sel = REG_CTRL_TWO;
            default: sel = REG_NONE;
        endcase
        return sel;
    endfunction

    // =========================================================
    // Bus answer code for a decoded register
    function automatic logic [1:0] respFor(input reg_sel_t sel);
        logic [1:0] code;
        code = `T16_RESP_OKAY;
        if (sel == REG_NONE) begin
            code = `T16_RESP_SLVERR;
        end
        return code;
    endfunction

    // =========================================================
    // Prescaler mask for the internal tick
    function automatic logic [2:0] prescMask(input logic [1:0] sel);
        logic [2:0] mask;
        mask = `T16_PRESC_DIV8;
        unique case (sel)
            2'h0: mask = `T16_PRESC_DIV2;
            2'h1: mask = `T16_PRESC_DIV4;
            2'h2: mask = `T16_PRESC_DIV8;
            2'h3: mask = `T16_PRESC_DIV8;
        endcase
        return mask;
    endfunction

    // =========================================================
    // Synchroniser stages agree on a new level
    function automatic logic syncAgreed(input logic [2:0] sync,
            input logic lvl);
        return (sync[2] == sync[1]) && (sync[2] != lvl);
    endfunction

    // =========================================================
    // Selected external edge: 0 rising, 1 falling
    function automatic logic activeEdge(input logic lvl,
            input logic fallSel);
        return lvl == ~fallSel;
    endfunction

    // =========================================================
    // Rollover point of the count
    function automatic logic isWrap(input logic [15:0] c);
        return c == `T16_CNT_MAX;
    endfunction

    // =========================================================
    // One count step, wrapping to zero
    function automatic logic [15:0] stepCount(input logic [15:0] c);
        return c + 16'h0001;
    endfunction

    // =========================================================
    // Byte registers sit in the low lane
    function automatic logic [31:0] rdWord(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // =========================================================
    // Low byte seen by a read: buffered inside a sequence
    function automatic logic [7:0] lowSeen(input logic inSeq,
            input logic [7:0] held, input logic [7:0] live);
        return inSeq ? held : live;
    endfunction

    // =========================================================
    // Next state
    always_comb begin
        logic pinIn;
        logic extEdge;
        logic [1:0] clkSel;
        logic [2:0] mask;
        logic tick;
        logic ovf;
        logic wrDo;
        logic rdDo;
        logic lowTouch;
        reg_sel_t wrSel;
        reg_sel_t rdSel;
        logic [7:0] rdByte;
        pinIn = EXT_PIN_BONDED ? extTimerClockPin : 1'b1;
        extEdge = 1'b0;
        clkSel = {st_r.ctrlTwo[`T16_BIT_CLK_SEL_HI],
            st_r.ctrlTwo[`T16_BIT_CLK_SEL_LO]};
        mask = prescMask(clkSel);
        tick = 1'b0;
        ovf = 1'b0;
        wrDo = 1'b0;
        rdDo = 1'b0;
        lowTouch = 1'b0;
        wrSel = decodeReg(st_r.awAddr);
        rdSel = decodeReg(axiReq.araddr);
        rdByte = 8'h00;
        st_nxt = st_r;

        // =====================================================
        // External pin synchroniser and edge detect
        st_nxt.extSync = {st_r.extSync[1:0], pinIn};
        if (syncAgreed(st_r.extSync, st_r.extLvl)) begin
            st_nxt.extLvl = st_r.extSync[2];
            extEdge = activeEdge(st_r.extSync[2],
                st_r.ctrlTwo[`T16_BIT_EXT_EDGE]);
        end

        // =====================================================
        // Tick source and counter
        if (!haltMode) begin
            // Wait mode has no input here: counting continues
            if (clkSel == `T16_CLK_SEL_EXT) begin
                tick = extEdge;
            end else begin
                st_nxt.presc = st_r.presc + 3'h1;
                tick = ((st_r.presc & mask) == mask);
                if (tick) begin
                    st_nxt.presc = 3'h0;
                end
            end
        end

        // =====================================================
        // Counter step
        if (tick) begin
            st_nxt.count = stepCount(st_r.count);
            ovf = isWrap(st_r.count);
        end

        // =====================================================
        // Write channel
        if (axiReq.awvalid && st_r.rsp.awready) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && st_r.rsp.wready) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = axiReq.wdata;
        end
        if (st_r.awHeld && st_r.wHeld && !st_r.rsp.bvalid) begin
            wrDo = 1'b1;
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = respFor(wrSel);
        end
        if (st_r.rsp.bvalid && axiReq.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end

        // =====================================================
        // Write decode
        if (wrDo) begin
            unique case (wrSel)
                REG_CNT_LOW: begin
                    st_nxt.count = `T16_CNT_RESET;
                    st_nxt.presc = 3'h0;
                    ovf = 1'b0;
                    lowTouch = 1'b1;
                end
                REG_SHD_LOW: begin
                    st_nxt.count = `T16_CNT_RESET;
                    st_nxt.presc = 3'h0;
                    ovf = 1'b0;
                end
                REG_CTRL_ONE: begin
                    st_nxt.ctrlOne = st_r.wData[7:0];
                end
                REG_CTRL_TWO: st_nxt.ctrlTwo = st_r.wData[7:0];
                default: ;
            endcase
        end

        // =====================================================
        // Channel readiness
        st_nxt.rsp.awready = !st_nxt.awHeld && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready = !st_nxt.wHeld && !st_nxt.rsp.bvalid;

        // =====================================================
        // Read channel
        if (axiReq.arvalid && st_r.rsp.arready) begin
            rdDo = 1'b1;
        end
        if (rdDo) begin
            unique case (rdSel)
                REG_CNT_HIGH, REG_SHD_HIGH: begin
                    rdByte = st_r.count[15:8];
                    if (!st_r.seqOpen) begin
                        st_nxt.seqOpen = 1'b1;
                        st_nxt.lowBuf = st_r.count[7:0];
                    end
                end
                REG_CNT_LOW, REG_SHD_LOW: begin
                    // Buffered byte inside a sequence, live after
                    rdByte = lowSeen(st_r.seqOpen, st_r.lowBuf,
                        st_r.count[7:0]);
                    st_nxt.seqOpen = 1'b0;
                    if (rdSel == REG_CNT_LOW) begin
                        lowTouch = 1'b1;
                    end
                end
                REG_STATUS: begin
                    rdByte = {7'h00, st_r.ovfFlag};
                    if (st_r.ovfFlag) begin
                        st_nxt.clrArmed = 1'b1;
                    end
                end
                REG_CTRL_ONE: rdByte = st_r.ctrlOne;
                REG_CTRL_TWO: rdByte = st_r.ctrlTwo;
                default: rdByte = 8'h00;
            endcase
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = rdWord(rdByte);
            st_nxt.rsp.rresp = respFor(rdSel);
        end else if (st_r.rsp.rvalid && axiReq.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

        // =====================================================
        // Overflow flag: set wins over clear
        if (lowTouch && st_r.clrArmed) begin
            st_nxt.ovfFlag = 1'b0;
            st_nxt.clrArmed = 1'b0;
        end
        if (ovf) begin
            st_nxt.ovfFlag = 1'b1;
        end

        // =====================================================
        // Interrupt request
        // Flag stays pending until enable and mask allow
        st_nxt.irq = st_nxt.ovfFlag &&
            st_nxt.ctrlOne[`T16_BIT_OVF_IRQ_EN] && !cpuIrqMask;
    end

    // =========================================================
    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.rsp.bvalid <= 1'b0;
            st_r.rsp.bresp <= `T16_RESP_OKAY;
            st_r.rsp.rvalid <= 1'b0;
            st_r.rsp.rdata <= 32'h00000000;
            st_r.rsp.rresp <= `T16_RESP_OKAY;
            st_r.awHeld <= 1'b0;
            st_r.awAddr <= 8'h00;
            st_r.wHeld <= 1'b0;
            st_r.wData <= 32'h00000000;
            st_r.presc <= 3'h0;
            st_r.seqOpen <= 1'b0;
            st_r.lowBuf <= 8'h00;
            st_r.ovfFlag <= 1'b0;
            st_r.clrArmed <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.rsp.awready <= 1'b1;
            st_r.rsp.wready <= 1'b1;
            st_r.rsp.arready <= 1'b1;
            st_r.count <= `T16_CNT_RESET;
            st_r.extSync <= 3'h7;
            st_r.extLvl <= 1'b1;
            st_r.ctrlOne <= `T16_CTRL_RESET;
            st_r.ctrlTwo <= `T16_CTRL_RESET;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // Outputs
    assign axiRsp = st_r.rsp;
    assign timerIrq = st_r.irq;
endmodule
`default_nettype wire

// ### tb/timer16_counter_overflow_properties.sv
`timescale 1ns/10ps
`default_nettype none
module timer16_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire timer16_pkg::axi_req_t axiReq,
    input wire timer16_pkg::axi_rsp_t axiRsp,
    input wire logic extTimerClockPin,
    input wire logic cpuIrqMask,
    input wire logic haltMode,
    input wire logic timerIrq
);
    import timer16_pkg::*;
    // ====
    // Bus and interrupt relations
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_arTake; axiReq.arvalid && axiRsp.arready && clkEn; endsequence
    sequence s_wTake;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
            && clkEn;
    endsequence
    property p_rdAnswer;
        s_arTake |=> axiRsp.rvalid;
    endproperty
    a_rdAnswer: assert property (p_rdAnswer)
        else $error("read not answered");
    property p_rdBad;
        s_arTake ##0 axiReq.araddr > 8'h18 |=> axiRsp.rresp == 2'h2;
    endproperty
    a_rdBad: assert property (p_rdBad)
        else $error("unmapped read not refused");
    property p_wrAnswer;
        s_wTake |-> ##2 axiRsp.bvalid;
    endproperty
    a_wrAnswer: assert property (p_wrAnswer)
        else $error("write not answered");
    property p_rdHold;
        axiRsp.rvalid && !axiReq.rready |=>
            axiRsp.rvalid && $stable(axiRsp.rdata);
    endproperty
    a_rdHold: assert property (p_rdHold)
        else $error("read data dropped");
    property p_bHold;
        axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid;
    endproperty
    a_bHold: assert property (p_bHold)
        else $error("write answer dropped");
    property p_arBlock;
        axiRsp.rvalid |-> !axiRsp.arready;
    endproperty
    a_arBlock: assert property (p_arBlock)
        else $error("read taken early");
    property p_byteData;
        axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0;
    endproperty
    a_byteData: assert property (p_byteData)
        else $error("upper bits set");
    property p_irqMask;
        cpuIrqMask && clkEn |=> !timerIrq;
    endproperty
    a_irqMask: assert property (p_irqMask)
        else $error("masked irq seen");
endmodule
bind timer16_counter_overflow timer16_checker u_timer16_checker (
    .core_clk, .rst, .clkEn, .axiReq, .axiRsp, .extTimerClockPin,
    .cpuIrqMask, .haltMode, .timerIrq);
`default_nettype wire

// ### tb/test_timer16_counter_overflow.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defs.svh"
module test_timer16_counter_overflow;
    import timer16_pkg::*;
    logic core_clk, rst, clkEn, extTimerClockPin, cpuIrqMask, haltMode;
    logic timerIrq;
    axi_req_t axiReq;
    axi_rsp_t axiRsp;
    logic [31:0] rd;
    logic [15:0] cnt;
    logic [1:0] resp;
    int failCount, compares, e;
    timer16_counter_overflow u_timer16_counter_overflow (
        .core_clk, .rst, .clkEn, .axiReq, .axiRsp, .extTimerClockPin,
        .cpuIrqMask, .haltMode, .timerIrq);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ====
    // Checks and bus access
    task automatic chk(input logic [31:0] g, lo, hi);
        compares++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, lo);
            failCount++;
        end
    endtask
    task automatic wrapUp();
        $display("compares %0d failCount %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bus(input bit wr, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge core_clk);
        axiReq.awaddr <= a;
        axiReq.araddr <= a;
        axiReq.wdata <= d;
        axiReq.awvalid <= wr;
        axiReq.wvalid <= wr;
        axiReq.bready <= wr;
        axiReq.arvalid <= !wr;
        axiReq.rready <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while ((wr ? axiRsp.bvalid : axiRsp.rvalid) !== 1'b1 && n < 40);
        rd = axiRsp.rdata;
        resp = wr ? axiRsp.bresp : axiRsp.rresp;
        axiReq.bready <= 1'b0;
        axiReq.rready <= 1'b0;
        if (n >= 40) begin
            failCount++;
            wrapUp();
        end
    endtask
    task automatic rdCnt(input logic [7:0] a);
        bus(0, a, 0);
        cnt[15:8] = rd[7:0];
        bus(0, a + 8'h04, 0);
        cnt[7:0] = rd[7:0];
    endtask
    // ====
    // Scenarios
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        extTimerClockPin = 1'b1;
        cpuIrqMask = 1'b1;
        haltMode = 1'b1;
        axiReq = '0;
        failCount = 0;
        compares = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdCnt(`T16_OFS_CNT_HIGH);
        chk(cnt, 16'hFFFC, 16'hFFFC);
        rdCnt(`T16_OFS_SHD_HIGH);
        chk(cnt, 16'hFFFC, 16'hFFFC);
        bus(0, `T16_OFS_CTRL_TWO, 0);
        chk(rd, 0, 0);
        bus(0, 8'h1C, 0);
        chk(resp, 2'h2, 2'h2);
        bus(0, `T16_OFS_CNT_HIGH, 0);
        haltMode <= 1'b0;
        repeat (40) @(posedge core_clk);
        haltMode <= 1'b1;
        bus(0, `T16_OFS_SHD_HIGH, 0);
        chk(rd, 0, 0);
        bus(0, `T16_OFS_CNT_LOW, 0);
        chk(rd, 32'hFC, 32'hFC);
        bus(0, `T16_OFS_SHD_LOW, 0);
        chk(rd, 32'h0E, 32'h11);
        bus(1, `T16_OFS_CNT_LOW, 32'h55);
        chk(resp, 2'h0, 2'h0);
        rdCnt(`T16_OFS_CNT_HIGH);
        chk(cnt, 16'hFFFC, 16'hFFFC);
        clkEn <= 1'b0;
        haltMode <= 1'b0;
        repeat (20) @(posedge core_clk);
        haltMode <= 1'b1;
        clkEn <= 1'b1;
        rdCnt(`T16_OFS_CNT_HIGH);
        chk(cnt, 16'hFFFC, 16'hFFFC);
        for (int i = 0; i < 3; i++) begin
            bus(1, `T16_OFS_CTRL_TWO, i);
            bus(1, `T16_OFS_SHD_LOW, 0);
            haltMode <= 1'b0;
            repeat (16 << i) @(posedge core_clk);
            haltMode <= 1'b1;
            rdCnt(`T16_OFS_SHD_HIGH);
            chk(cnt, 16'h0003, 16'h0005);
        end
        for (int m = 3; m < 8; m += 4) begin
            bus(1, `T16_OFS_CTRL_TWO, m);
            bus(1, `T16_OFS_SHD_LOW, 0);
            haltMode <= 1'b0;
            e = 0;
            repeat (3) begin
                repeat (8) @(posedge core_clk);
                e += (extTimerClockPin != (m == 3));
                extTimerClockPin <= ~extTimerClockPin;
            end
            repeat (8) @(posedge core_clk);
            haltMode <= 1'b1;
            rdCnt(`T16_OFS_SHD_HIGH);
            chk(cnt, 16'hFFFC + e, 16'hFFFC + e);
        end
        bus(1, `T16_OFS_CTRL_ONE, 1);
        bus(0, `T16_OFS_CTRL_ONE, 0);
        chk(rd, 1, 1);
        chk(timerIrq, 0, 0);
        cpuIrqMask <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(timerIrq, 1, 1);
        bus(0, `T16_OFS_CNT_LOW, 0);
        bus(0, `T16_OFS_STATUS, 0);
        chk(rd, 1, 1);
        bus(0, `T16_OFS_SHD_LOW, 0);
        bus(0, `T16_OFS_STATUS, 0);
        chk(rd, 1, 1);
        bus(0, `T16_OFS_CNT_LOW, 0);
        bus(0, `T16_OFS_STATUS, 0);
        chk(rd, 0, 0);
        chk(timerIrq, 0, 0);
        wrapUp();
    end
endmodule
`default_nettype wire
